// ---- src/wdt_defs.sv ----
// Shared constants and types for the window watchdog, plus its tick divider.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps

package wdt_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 100000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_US = TICK_NS / 1000;
  localparam int TW = 20;
  // Factory window, selects both high
  localparam int WIN_LO_11_US = 800000;
  localparam int WIN_UP_11_US = 1600000;
  // Factory window, selects both low: lower rounds down, upper rounds up
  localparam int WIN_LO_00_US = 25900;
  localparam int WIN_UP_00_US = 46800;
  localparam logic [TW-1:0] WIN_LO_11_TICKS = TW'(WIN_LO_11_US / TICK_US);
  localparam logic [TW-1:0] WIN_UP_11_TICKS = TW'((WIN_UP_11_US + TICK_US - 1) / TICK_US);
  localparam logic [TW-1:0] WIN_LO_00_TICKS = TW'(WIN_LO_00_US / TICK_US);
  localparam logic [TW-1:0] WIN_UP_00_TICKS = TW'((WIN_UP_00_US + TICK_US - 1) / TICK_US);
  // Factory fault hold time
  localparam int HOLD_MS = 200;
  localparam logic [TW-1:0] HOLD_TICKS = TW'((HOLD_MS * 1000 + TICK_US - 1) / TICK_US);
  // Reset values
  localparam logic [TW-1:0] CNT_RST = 20'h00000;
  localparam logic [23:0] RAMP_RST = 24'h000000;

  typedef enum logic [1:0] {DLY_OPEN, DLY_PULLUP, DLY_CAP} delay_mode_type;

  typedef struct packed {
    logic enabled;
    logic [TW-1:0] lower;
    logic [TW-1:0] upper;
  } window_cfg_type;
endpackage : wdt_pkg

module wdt_tick_gen #(
  parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Restart the tick period
  input wire logic clr_in,
  // One-cycle pulse per time base period
  output logic tick_out
);
  logic [31:0] div_ff;
  logic [31:0] nxt_div;
  logic nxt_tick;
  logic tick_ff;

  // Divider wraps at the period; clear aligns ticks to state changes
  always_comb
  begin
    nxt_tick = 1'b0;
    nxt_div = div_ff + 32'h00000001;
    if (clr_in)
    begin
      nxt_div = 32'h00000000;
    end
    else if (div_ff == 32'(TICK_CYCLES - 1))
    begin
      nxt_div = 32'h00000000;
      nxt_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      div_ff <= 32'h00000000;
      tick_ff <= 1'b0;
    end
    else
    begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  assign tick_out = tick_ff;
endmodule : wdt_tick_gen

// ---- src/window_watchdog_timer.sv ----
// Window watchdog: kick edge checking, fault hold timing, open-drain fault pin.
// Assumes all inputs synchronous to clk_in; capacitor pins are modelled digitally.
//
// Contract
// - With the delay pin open the fault hold lasts the factory 200 ms.
// - A missing kick past the timeout asserts the fault output for the hold time.
// - Once the hold time ends the fault output is released and stays high while kicks land inside the window.
// - A kick before the lower bound or after the upper bound causes a fault.
// - Factory window with both selects high is 800 ms lower and 1.6 s upper.
// - Factory window with both selects low has lower at most 25.9 ms and upper at least 46.8 ms.
// - Hold time is set by capacitor, pull-up or open pin, the latter two giving the factory delay.
// - With a capacitor the hold ends after an initial delay plus a constant-current ramp to threshold.
// - The window may come from a capacitor instead of the factory options.
`timescale 1ns/1ps

module window_watchdog_timer #(
  parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES,
  parameter int FACT01_LO_US = 100000,
  parameter int FACT01_UP_US = 200000,
  parameter int INIT_US = 1000,
  parameter int RW = 24
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Kick from the monitored controller, falling edge counts
  input wire logic kick_input_in,
  // Window selection
  input wire logic window_select_lo_in,
  input wire logic window_select_hi_in,
  input wire logic window_cap_present_in,
  input wire logic [wdt_pkg::TW-1:0] window_cap_upper_in,
  // Reset delay selection and capacitor model
  input wire wdt_pkg::delay_mode_type reset_delay_mode_in,
  input wire logic [RW-1:0] reset_delay_cap_step_in,
  input wire logic [RW-1:0] reset_delay_cap_thresh_in,
  // Open-drain fault pin
  output logic fault_output_n_out,
  output logic fault_output_oe_out
);
  localparam logic [wdt_pkg::TW-1:0] WIN_LO_01_TICKS = wdt_pkg::TW'(FACT01_LO_US / wdt_pkg::TICK_US);
  localparam logic [wdt_pkg::TW-1:0] WIN_UP_01_TICKS =
    wdt_pkg::TW'((FACT01_UP_US + wdt_pkg::TICK_US - 1) / wdt_pkg::TICK_US);
  localparam logic [wdt_pkg::TW-1:0] INIT_TICKS = wdt_pkg::TW'((INIT_US + wdt_pkg::TICK_US - 1) / wdt_pkg::TICK_US);

  typedef enum logic {ST_WATCH, ST_FAULT} state_type;

  wdt_pkg::window_cfg_type cfg;
  logic [wdt_pkg::TW+1:0] cap3;
  state_type state_ff;
  state_type nxt_state;
  logic [wdt_pkg::TW-1:0] win_cnt_ff;
  logic [wdt_pkg::TW-1:0] nxt_win_cnt;
  logic [wdt_pkg::TW-1:0] hold_cnt_ff;
  logic [wdt_pkg::TW-1:0] nxt_hold_cnt;
  logic [RW-1:0] ramp_ff;
  logic [RW-1:0] nxt_ramp;
  logic kick_prev_ff;
  logic nxt_kick_prev;
  logic kick_fall;
  logic tick;
  logic tick_clr;
  logic early;
  logic late;
  logic hold_done;

  // Window bounds from pins; select lo high with hi low disables watching
  always_comb
  begin
    cap3 = {2'b00, window_cap_upper_in} * 22'h000003;
    cfg.enabled = 1'b1;
    cfg.lower = wdt_pkg::CNT_RST;
    cfg.upper = wdt_pkg::CNT_RST;
    if (window_select_lo_in && !window_select_hi_in)
    begin
      cfg.enabled = 1'b0;
    end
    else if (window_cap_present_in)
    begin
      cfg.upper = window_cap_upper_in;
      if (!window_select_lo_in && !window_select_hi_in)
        cfg.lower = window_cap_upper_in >> 3;
      else if (!window_select_lo_in)
        cfg.lower = cap3[wdt_pkg::TW+1:2];
      else
        cfg.lower = window_cap_upper_in >> 1;
    end
    else if (window_select_lo_in && window_select_hi_in)
    begin
      cfg.lower = wdt_pkg::WIN_LO_11_TICKS;
      cfg.upper = wdt_pkg::WIN_UP_11_TICKS;
    end
    else if (!window_select_lo_in && !window_select_hi_in)
    begin
      cfg.lower = wdt_pkg::WIN_LO_00_TICKS;
      cfg.upper = wdt_pkg::WIN_UP_00_TICKS;
    end
    else
    begin
      cfg.lower = WIN_LO_01_TICKS;
      cfg.upper = WIN_UP_01_TICKS;
    end
  end

  // Time base; restarted on every state change so holds are exact
  wdt_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .clr_in(tick_clr),
    .tick_out(tick)
  );

  // Kick edge and window checks
  always_comb
  begin
    nxt_kick_prev = kick_input_in;
    kick_fall = kick_prev_ff && !kick_input_in;
    early = kick_fall && (win_cnt_ff < cfg.lower);
    late = win_cnt_ff >= cfg.upper;
  end

  // Hold end: factory count, or initial delay then ramp reaching threshold
  always_comb
  begin
    if (reset_delay_mode_in == wdt_pkg::DLY_CAP)
      hold_done = (hold_cnt_ff >= INIT_TICKS) && (ramp_ff >= reset_delay_cap_thresh_in);
    else
      hold_done = tick && (hold_cnt_ff == wdt_pkg::HOLD_TICKS - 20'h00001);
  end

  // Main state and counters
  always_comb
  begin
    nxt_state = state_ff;
    nxt_win_cnt = win_cnt_ff;
    nxt_hold_cnt = hold_cnt_ff;
    nxt_ramp = ramp_ff;
    tick_clr = 1'b0;
    case (state_ff)
      ST_WATCH:
      begin
        if (!cfg.enabled)
        begin
          nxt_win_cnt = wdt_pkg::CNT_RST;
        end
        else if (early || late)
        begin
          nxt_state = ST_FAULT;
          nxt_hold_cnt = wdt_pkg::CNT_RST;
          nxt_ramp = wdt_pkg::RAMP_RST;
          tick_clr = 1'b1;
        end
        else if (kick_fall)
        begin
          nxt_win_cnt = wdt_pkg::CNT_RST;
          tick_clr = 1'b1;
        end
        else if (tick)
        begin
          nxt_win_cnt = win_cnt_ff + 20'h00001;
        end
      end
      ST_FAULT:
      begin
        // Kick edges are not looked at here
        if (hold_done)
        begin
          nxt_state = ST_WATCH;
          nxt_win_cnt = wdt_pkg::CNT_RST;
          tick_clr = 1'b1;
        end
        else if (tick)
        begin
          if (hold_cnt_ff != {wdt_pkg::TW{1'b1}})
            nxt_hold_cnt = hold_cnt_ff + 20'h00001;
          // Constant current: equal voltage step per tick after the initial delay
          if (reset_delay_mode_in == wdt_pkg::DLY_CAP && hold_cnt_ff >= INIT_TICKS)
            nxt_ramp = (ramp_ff > ~reset_delay_cap_step_in) ? {RW{1'b1}} : ramp_ff + reset_delay_cap_step_in;
        end
      end
      default:
      begin
        nxt_state = ST_WATCH;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state_ff <= ST_WATCH;
      win_cnt_ff <= wdt_pkg::CNT_RST;
      hold_cnt_ff <= wdt_pkg::CNT_RST;
      ramp_ff <= wdt_pkg::RAMP_RST;
      kick_prev_ff <= 1'b0; // Low: a line held low through reset must not look like a kick
    end
    else
    begin
      state_ff <= nxt_state;
      win_cnt_ff <= nxt_win_cnt;
      hold_cnt_ff <= nxt_hold_cnt;
      ramp_ff <= nxt_ramp;
      kick_prev_ff <= nxt_kick_prev;
    end
  end

  // Pin pulled low only while faulted; pull-up supplies the high
  assign fault_output_n_out = (state_ff != ST_FAULT);
  assign fault_output_oe_out = (state_ff == ST_FAULT);

  sequence s_enter_fault;
    state_ff == ST_WATCH && cfg.enabled && (early || late);
  endsequence

  sequence s_good_kick;
    state_ff == ST_WATCH && cfg.enabled && kick_fall && !early && !late;
  endsequence

  AST_FAULT_PIN: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state_ff == ST_FAULT) |-> (!fault_output_n_out && fault_output_oe_out))
    else $error("fault pin not driven low while faulted");

  AST_TIMEOUT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state_ff == ST_WATCH && cfg.enabled && late) |=> !fault_output_n_out)
    else $error("timeout did not assert fault");

  AST_EARLY_KICK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_enter_fault |=> (state_ff == ST_FAULT && hold_cnt_ff == 20'h00000) ##1 !fault_output_n_out)
    else $error("early or late kick did not fault");

  AST_GOOD_KICK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_good_kick |=> (fault_output_n_out && win_cnt_ff == 20'h00000))
    else $error("in-window kick did not restart window");

  AST_IGNORE_KICK: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state_ff == ST_FAULT && !hold_done) |=> (state_ff == ST_FAULT && $stable(win_cnt_ff)))
    else $error("fault released before hold end");

  AST_RESTART: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state_ff == ST_FAULT && hold_done) |=> (fault_output_n_out && win_cnt_ff == 20'h00000))
    else $error("window not restarted on release");

  AST_FACTORY_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ($fell(fault_output_oe_out) && !$past(sys_rst_in) && $past(reset_delay_mode_in) != wdt_pkg::DLY_CAP)
    |-> ($past(hold_cnt_ff) == wdt_pkg::HOLD_TICKS - 20'h00001))
    else $error("factory hold length wrong");

  AST_CAP_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state_ff == ST_FAULT && reset_delay_mode_in == wdt_pkg::DLY_CAP && nxt_state == ST_WATCH)
    |-> (hold_cnt_ff >= INIT_TICKS && ramp_ff >= reset_delay_cap_thresh_in))
    else $error("capacitor hold ended early");

  AST_WIN_11: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!window_cap_present_in && window_select_lo_in && window_select_hi_in)
    |-> (cfg.lower == 20'h01F40 && cfg.upper == 20'h03E80))
    else $error("factory window 11 wrong");

  AST_WIN_00: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (!window_cap_present_in && !window_select_lo_in && !window_select_hi_in)
    |-> (cfg.lower <= 20'h00103 && cfg.upper >= 20'h001D4))
    else $error("factory window 00 out of range");

  AST_DISABLED: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (state_ff == ST_WATCH && !cfg.enabled) |=> fault_output_n_out)
    else $error("fault while disabled");
endmodule : window_watchdog_timer

// ---- sim/kick_source.sv ----
// Kick model of the monitored controller: one falling edge per call.
// Assumes the caller picks gaps that suit the selected window.
`timescale 1ns/1ps

module kick_source (
  // Clock
  input wire logic clk_in,
  // Kick line to the watchdog
  output logic kick_out
);
  // Idle low, so only the deliberate 1 then 0 pair forms an edge
  initial kick_out = 1'b0;

  // Waits the gap, then one high cycle and the falling edge
  task automatic send(input int gap_cycles);
    repeat (gap_cycles) @(posedge clk_in);
    kick_out <= 1'b1;
    @(posedge clk_in);
    kick_out <= 1'b0;
    @(posedge clk_in);
  endtask : send
endmodule : kick_source

// ---- sim/window_watchdog_timer_tb.sv ----
// Testbench for the window watchdog: timeout, window bounds and hold times.
// Assumes the kick model in kick_source.sv and a shortened tick divider.
`timescale 1ns/1ps

module window_watchdog_timer_tb;
  localparam int T = 4;
  localparam int HOLD = 2000 * T;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b0;
  logic cap_present = 1'b0;
  logic [19:0] cap_upper = 20'h00064;
  wdt_pkg::delay_mode_type dly_mode = wdt_pkg::DLY_OPEN;
  logic [23:0] cap_step = 24'h000005;
  logic [23:0] cap_thresh = 24'h000064;
  logic kick;
  logic fault_n;
  logic fault_oe;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  int m;
  int gaps[3] = '{262, 300, 465};

  initial forever #5 clk_in = ~clk_in;

  // Short tick keeps the factory hold near 8000 cycles
  window_watchdog_timer #(.TICK_CYCLES(T)) DUT (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .kick_input_in(kick),
    .window_select_lo_in(sel_lo),
    .window_select_hi_in(sel_hi),
    .window_cap_present_in(cap_present),
    .window_cap_upper_in(cap_upper),
    .reset_delay_mode_in(dly_mode),
    .reset_delay_cap_step_in(cap_step),
    .reset_delay_cap_thresh_in(cap_thresh),
    .fault_output_n_out(fault_n),
    .fault_output_oe_out(fault_oe)
  );

  kick_source u_kick (
    .clk_in(clk_in),
    .kick_out(kick)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait on the pin, sampled on the falling edge clear of updates
  task automatic wait_lvl(input logic lvl, input int limit, output int cnt);
    cnt = 0;
    while (fault_n !== lvl && cnt < limit)
    begin
      @(negedge clk_in);
      cnt++;
    end
  endtask : wait_lvl

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // Hang guard, well above the roughly 63000 cycles of the sequence
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(negedge clk_in);
    check(fault_n, 1'b1);
    check(fault_oe, 1'b0);
    // No kicks with selects low: timeout at the upper bound
    wait_lvl(1'b0, 470 * T, n);
    check(n >= 467 * T && n <= 469 * T, 1'b1);
    check(fault_oe, 1'b1);
    // A kick inside the hold must neither end nor stretch it
    u_kick.send(100);
    wait_lvl(1'b1, HOLD, m);
    check(m + 102 >= HOLD - 3 && m + 102 <= HOLD + 6, 1'b1);
    check(fault_oe, 1'b0);
    // Kicks inside the window, near both edges, keep the pin high
    foreach (gaps[i])
    begin
      u_kick.send(gaps[i] * T);
      wait_lvl(1'b0, 4, n);
      check(n, 4);
    end
    // Disable code: no timeout however long
    @(posedge clk_in);
    sel_lo <= 1'b1;
    wait_lvl(1'b0, 600 * T, n);
    check(n, 600 * T);
    // Early kick with the pull-up delay option
    @(posedge clk_in);
    sel_lo <= 1'b0;
    dly_mode <= wdt_pkg::DLY_PULLUP;
    u_kick.send(255 * T);
    wait_lvl(1'b0, 4, n);
    check(n < 4, 1'b1);
    wait_lvl(1'b1, HOLD + 8, m);
    check(m >= HOLD - 3 && m <= HOLD + 4, 1'b1);
    // Capacitor window of 100 ticks, lower half, and capacitor hold
    @(posedge clk_in);
    dly_mode <= wdt_pkg::DLY_CAP;
    cap_present <= 1'b1;
    sel_lo <= 1'b1;
    sel_hi <= 1'b1;
    u_kick.send(40 * T);
    wait_lvl(1'b0, 4, n);
    check(n < 4, 1'b1);
    // Hold is 10 initial ticks plus 20 ramp steps to threshold
    wait_lvl(1'b1, 40 * T, m);
    check(m >= 27 * T && m <= 33 * T, 1'b1);
    u_kick.send(70 * T);
    wait_lvl(1'b0, 4, n);
    check(n, 4);
    // Capacitor window, selects 01: lower is three quarters of 100 ticks
    @(posedge clk_in);
    sel_lo <= 1'b0;
    u_kick.send(60 * T);
    wait_lvl(1'b0, 4, n);
    check(n < 4, 1'b1);
    wait_lvl(1'b1, 40 * T, m);
    check(m >= 27 * T && m <= 33 * T, 1'b1);
    u_kick.send(80 * T);
    wait_lvl(1'b0, 4, n);
    check(n, 4);
    // Capacitor window, selects 00: lower is one eighth of 100 ticks
    @(posedge clk_in);
    sel_hi <= 1'b0;
    u_kick.send(20 * T);
    wait_lvl(1'b0, 4, n);
    check(n, 4);
    // Factory window, selects 01: 1000 to 2000 ticks by default
    @(posedge clk_in);
    cap_present <= 1'b0;
    sel_hi <= 1'b1;
    dly_mode <= wdt_pkg::DLY_OPEN;
    u_kick.send(1010 * T);
    wait_lvl(1'b0, 4, n);
    check(n, 4);
    // Factory window with selects high: just under 8000 ticks is early
    @(posedge clk_in);
    sel_lo <= 1'b1;
    u_kick.send(7990 * T);
    wait_lvl(1'b0, 4, n);
    check(n < 4, 1'b1);
    test_done();
  end
endmodule : window_watchdog_timer_tb
